// >>> inc/video_sync_map.svh
/*
  constants for the sync, clamp, clock and test-shift control block.
  assumes it is included once per compile unit by its bare name.
*/
`ifndef VIDEO_SYNC_MAP_SVH
`define VIDEO_SYNC_MAP_SVH
`define TEST_BITS            48
`define OUT_PORTS            6
`define OUT_WIDTH            8
`define ADDR_W               8
`define REG_SYNC_CTRL        8'h0F
`define REG_CLAMP_CTRL       8'h10
`define REG_CLAMP_DELAY      8'h11
`define REG_CLAMP_WIDTH      8'h12
`define REG_HSO_DELAY        8'h13
`define REG_HSO_WIDTH        8'h14
`define REG_STATUS           8'h15
`define REG_MODE             8'h16
`define BIT_HSYNC_POL        7
`define BIT_HSO_POL          6
`define BIT_VSO_POL          5
`define BIT_COAST_POL        4
`define BIT_VSYNC_SRC        3
`define BIT_EXT_CLAMP        7
`define BIT_CLAMP_POL        6
`define BIT_YUV              5
`define BIT_EXT_CLK          4
`define BIT_DIGITAL          0
`define BIT_DUAL             1
`define BIT_TEST             2
`define BIT_PWRDN            3
`define SYNC_CTRL_RST        8'h10
`define CLAMP_CTRL_RST       8'h00
`define CLAMP_DELAY_RST      8'h08
`define CLAMP_WIDTH_RST      8'h14
`define HSO_WIDTH_RST        8'h20
`define HSO_DELAY_RST        8'h00
`define MODE_RST             8'h00
`define ACT_TIMEOUT_RST      16'hFFFF
`endif

// >>> inc/video_sync_pkg.sv
/*
  types for the sync, clamp, clock and test-shift control block.
  assumes the map header is compiled alongside.
*/
`default_nettype none
package video_sync_pkg;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;
  typedef enum logic [1:0] {HS_IDLE, HS_DELAY, HS_PULSE} hso_state_e;
  typedef struct packed {
    logic clamp_active;
    logic clamp_mid;
    logic coast_hold;
    logic use_ext_clk;
    logic invert_clk;
  } analog_ctl_s;
endpackage
`default_nettype wire

// >>> hdl/video_sync_clock_pin_control.sv
/*
  control logic behind the shared and analog sync, clamp, clock and
  test-shift pins of a dual analog/digital display receiver.
  assumes all inputs synchronous to clk, including the test-shift clock,
  which is sampled and edge detected; registers on a plain strobe port.
*/
// Strobed register access and the address map are this design's own decisions.
// What this block does
// - hsync output regenerated, phase aligned, selectable polarity
// - analog: programmable position/width; digital: follows transmitter
// - vsync output: separated or passthrough, selectable polarity
// - activity high on hsync in analog mode, de in digital, else low
// - activity low three-states all pixel outputs
// - test mode loads 48 serial bits onto outputs
// - test-shift output returns bits first-in first-out
// - one test-shift clock times shift in and out
// - leading hsync edge only, polarity bit seven
// - external clamp honoured only when enable bit set
// - otherwise clamp timed from hsync trailing edge
// - clamp polarity bit selects external clamp level
// - clamp to ground for rgb, midscale for yuv
// - coast freezes clock generator tracking of hsync
// - coast polarity bit, default one
// - external clock select replaces sync-derived clock
// - invert input flips sampling clock 180 degrees
// - msb on bit seven, ports shared
// - dual mode: first pixel port a, alternating
// - output clock pixel rate single, half dual
`timescale 1ns/1ps
`default_nettype none
`include "video_sync_map.svh"
module video_sync_clock_pin_control
  import video_sync_pkg::*;
#(
  parameter int TEST_BITS = `TEST_BITS,
  parameter int ACT_WIDTH = 16
)(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic               hsync_in,
  input  wire logic               vsync_in,
  input  wire logic               csync_vsync,
  input  wire logic               digital_hsync,
  input  wire logic               digital_vsync,
  input  wire logic               digital_de,
  input  wire logic               clamp_in,
  input  wire logic               coast_in,
  input  wire logic               sample_clock_invert,
  input  wire logic               pixel_valid,
  input  wire pixel_s             pixel_in,
  input  wire logic               test_shift_clock,
  input  wire logic               test_shift_in,
  output logic                    test_shift_out,
  output logic                    horiz_sync_output,
  output logic                    vert_sync_output,
  output logic                    pixel_out_clock,
  output logic                    activity_detect,
  output pixel_s                  port_a_o,
  output pixel_s                  port_b_o,
  output logic                    port_a_oe,
  output logic                    port_b_oe,
  output analog_ctl_s             analog_ctl
);
  if (TEST_BITS != `OUT_PORTS * `OUT_WIDTH)
  begin
    $error("test register must fill the six output ports");
  end
  if (ACT_WIDTH < 2 || ACT_WIDTH > 16)
  begin
    $error("activity timeout width out of range");
  end

  logic [7:0]  sync_ctrl_r;
  logic [7:0]  clamp_ctrl_r;
  logic [7:0]  clamp_delay_r;
  logic [7:0]  clamp_width_r;
  logic [7:0]  hso_delay_r;
  logic [7:0]  hso_width_r;
  logic [7:0]  mode_r;

  // software-written controls
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_ctrl_r   <= `SYNC_CTRL_RST;
      clamp_ctrl_r  <= `CLAMP_CTRL_RST;
      clamp_delay_r <= `CLAMP_DELAY_RST;
      clamp_width_r <= `CLAMP_WIDTH_RST;
      hso_delay_r   <= `HSO_DELAY_RST;
      hso_width_r   <= `HSO_WIDTH_RST;
      mode_r        <= `MODE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_SYNC_CTRL:   sync_ctrl_r   <= reg_wdata;
        `REG_CLAMP_CTRL:  clamp_ctrl_r  <= reg_wdata;
        `REG_CLAMP_DELAY: clamp_delay_r <= reg_wdata;
        `REG_CLAMP_WIDTH: clamp_width_r <= reg_wdata;
        `REG_HSO_DELAY:   hso_delay_r   <= reg_wdata;
        `REG_HSO_WIDTH:   hso_width_r   <= reg_wdata;
        `REG_MODE:        mode_r        <= reg_wdata;
        default:          ;
      endcase
    end
  end

  logic digital_mode;
  logic dual_mode;
  logic test_mode;
  logic pwrdn;
  assign digital_mode = mode_r[`BIT_DIGITAL];
  assign dual_mode    = mode_r[`BIT_DUAL];
  assign test_mode    = mode_r[`BIT_TEST];
  assign pwrdn        = mode_r[`BIT_PWRDN];

  // hsync edge detection, polarity normalised to active high
  logic hs_norm;
  logic hs_prev_r;
  logic hs_lead;
  logic hs_trail;
  assign hs_norm  = hsync_in ~^ sync_ctrl_r[`BIT_HSYNC_POL];
  assign hs_lead  = hs_norm & ~hs_prev_r;
  assign hs_trail = ~hs_norm & hs_prev_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hs_prev_r <= 1'b0;
    else
      hs_prev_r <= hs_norm;
  end

  // activity: retriggerable timeout on the selected interface's activity: de in digital mode, hsync leading edge in analog
  logic [ACT_WIDTH-1:0] act_cnt_r;
  logic                 act_event;
  assign act_event = digital_mode ? digital_de : hs_lead;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      act_cnt_r <= '0;
    else if (pwrdn)
      act_cnt_r <= '0;
    else if (act_event)
      act_cnt_r <= '1;
    else if (act_cnt_r != '0)
      act_cnt_r <= act_cnt_r - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      activity_detect <= 1'b0;
    else
      activity_detect <= (act_cnt_r != '0) && !pwrdn;
  end

  // analog hsync output timing: delay then width after leading edge
  hso_state_e  hso_state_r;
  logic [7:0]  hso_cnt_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hso_state_r <= HS_IDLE;
      hso_cnt_r   <= 8'h00;
    end
    else
    begin
      case (hso_state_r)
        HS_IDLE:
          if (hs_lead)
          begin
            hso_state_r <= (hso_delay_r == 8'h00) ? HS_PULSE : HS_DELAY;
            hso_cnt_r   <= (hso_delay_r == 8'h00) ? hso_width_r
                                                  : hso_delay_r;
          end
        HS_DELAY:
          if (hso_cnt_r <= 8'h01)
          begin
            hso_state_r <= HS_PULSE;
            hso_cnt_r   <= hso_width_r;
          end
          else
            hso_cnt_r <= hso_cnt_r - 8'h01;
        HS_PULSE:
          if (hso_cnt_r <= 8'h01)
            hso_state_r <= HS_IDLE;
          else
            hso_cnt_r <= hso_cnt_r - 8'h01;
        default:
          hso_state_r <= HS_IDLE;
      endcase
    end
  end

  // sync outputs registered with the data so they stay aligned
  logic hs_active;
  logic vs_active;
  assign hs_active = digital_mode ? digital_hsync
                                  : (hso_state_r == HS_PULSE);
  assign vs_active = digital_mode ? digital_vsync
                   : (sync_ctrl_r[`BIT_VSYNC_SRC] ? csync_vsync
                                                  : vsync_in);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      horiz_sync_output <= 1'b0;
      vert_sync_output  <= 1'b0;
    end
    else
    begin
      horiz_sync_output <= hs_active ^ ~sync_ctrl_r[`BIT_HSO_POL];
      vert_sync_output  <= vs_active ^ ~sync_ctrl_r[`BIT_VSO_POL];
    end
  end

  // internal clamp window counted from the hsync trailing edge
  logic [8:0] clamp_cnt_r;
  logic       clamp_int_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clamp_cnt_r <= 9'h000;
      clamp_int_r <= 1'b0;
    end
    else if (hs_trail)
    begin
      clamp_cnt_r <= {1'b0, clamp_delay_r} + {1'b0, clamp_width_r};
      clamp_int_r <= 1'b0;
    end
    else if (clamp_cnt_r != 9'h000)
    begin
      clamp_cnt_r <= clamp_cnt_r - 9'h001;
      clamp_int_r <= (clamp_cnt_r <= {1'b0, clamp_width_r});
    end
    else
      clamp_int_r <= 1'b0;
  end

  logic clamp_ext;
  assign clamp_ext = clamp_in ~^ clamp_ctrl_r[`BIT_CLAMP_POL];

  // analog front-end controls, registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      analog_ctl <= '0;
    else
    begin
      analog_ctl.clamp_active <= clamp_ctrl_r[`BIT_EXT_CLAMP] ? clamp_ext
                                 : clamp_int_r;
      analog_ctl.clamp_mid    <= clamp_ctrl_r[`BIT_YUV];
      analog_ctl.coast_hold   <= coast_in
                                 ~^ sync_ctrl_r[`BIT_COAST_POL];
      analog_ctl.use_ext_clk  <= clamp_ctrl_r[`BIT_EXT_CLK];
      // changing phase mid-line corrupts samples; the controller
      // is trusted to switch only in blanking
      analog_ctl.invert_clk   <= sample_clock_invert;
    end
  end

  // test-shift clock sampled; one edge times both directions
  logic tsc_prev_r;
  logic tsc_rise;
  logic [TEST_BITS-1:0] test_r;
  assign tsc_rise = test_shift_clock & ~tsc_prev_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tsc_prev_r <= 1'b0;
    else
      tsc_prev_r <= test_shift_clock;
  end

  // each new bit enters at bit 0; oldest bit leaves at the top
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      test_r <= '0;
    else if (test_mode && tsc_rise)
      test_r <= {test_r[TEST_BITS-2:0], test_shift_in};
  end
  assign test_shift_out = test_r[TEST_BITS-1];

  // pixel routing in dual mode: first after hsync to port a, then alternate
  logic   phase_r;
  logic   clk_div_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      phase_r <= 1'b0;
    else if (hs_lead)
      phase_r <= 1'b0;
    else if (pixel_valid)
      phase_r <= ~phase_r;
  end

  // output clock: toggle per pixel in single mode, per pair in dual
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clk_div_r <= 1'b0;
    else if (pixel_valid && (!dual_mode || phase_r))
      clk_div_r <= ~clk_div_r;
  end
  assign pixel_out_clock = clk_div_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_a_o <= '0;
      port_b_o <= '0;
    end
    else if (test_mode)
    begin
      // fixed order, same as shift order: oldest byte on port a red
      port_a_o <= test_r[47:24];
      port_b_o <= test_r[23:0];
    end
    else if (pixel_valid)
    begin
      if (!dual_mode || !phase_r)
        port_a_o <= pixel_in;
      if (dual_mode && phase_r)
        port_b_o <= pixel_in;
    end
  end

  // port b only carries data in dual mode or test mode
  assign port_a_oe = activity_detect;
  assign port_b_oe = port_a_oe && (dual_mode || test_mode);

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_SYNC_CTRL:   reg_rdata <= sync_ctrl_r;
        `REG_CLAMP_CTRL:  reg_rdata <= clamp_ctrl_r;
        `REG_CLAMP_DELAY: reg_rdata <= clamp_delay_r;
        `REG_CLAMP_WIDTH: reg_rdata <= clamp_width_r;
        `REG_HSO_DELAY:   reg_rdata <= hso_delay_r;
        `REG_HSO_WIDTH:   reg_rdata <= hso_width_r;
        `REG_MODE:        reg_rdata <= mode_r;
        `REG_STATUS:      reg_rdata <= {3'b000, analog_ctl.coast_hold,
                                        analog_ctl.clamp_active, phase_r,
                                        horiz_sync_output, activity_detect};
        default:          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// >>> testbench/video_sync_assertions.sv
/*
  checker for the sync, clamp, clock and test-shift control block.
  assumes it is bound to the block's top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_sync_map.svh"
module video_sync_checker
  import video_sync_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               clamp_in,
  input wire logic               coast_in,
  input wire logic               sample_clock_invert,
  input wire logic               test_shift_clock,
  input wire logic               test_shift_out,
  input wire logic               activity_detect,
  input wire logic               port_a_oe,
  input wire logic               port_b_oe,
  input wire analog_ctl_s        analog_ctl
);
  logic [7:0] sync_r;
  logic [7:0] clmp_r;
  logic [7:0] mode_r;
  // shadows rebuilt from the strobe port, so no hierarchy peeking is needed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_r <= `SYNC_CTRL_RST;
      clmp_r <= `CLAMP_CTRL_RST;
      mode_r <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `REG_SYNC_CTRL)
        sync_r <= reg_wdata;
      if (reg_addr == `REG_CLAMP_CTRL)
        clmp_r <= reg_wdata;
      if (reg_addr == `REG_MODE)
        mode_r <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OE_A: assert property (port_a_oe |-> activity_detect)
    else $error("port a driven while inactive");
  AST_OE_B: assert property (port_b_oe |->
    activity_detect && (mode_r[1] || mode_r[2]))
    else $error("port b driven while inactive or single");
  AST_INV: assert property ($past(rst_n) |->
    analog_ctl.invert_clk == $past(sample_clock_invert))
    else $error("invert does not follow input");
  AST_SHIFT_OUT: assert property ($changed(test_shift_out) |->
    $past(test_shift_clock) && !$past(test_shift_clock, 2))
    else $error("shift output moved without shift clock edge");
  AST_COAST: assert property ($past(rst_n) |->
    analog_ctl.coast_hold == ($past(coast_in) == $past(sync_r[4])))
    else $error("coast hold wrong for input and sense");
  AST_EXT_CLK: assert property ($past(rst_n) |->
    analog_ctl.use_ext_clk == $past(clmp_r[4]))
    else $error("external clock select not applied");
  AST_EXT_CLAMP: assert property (
    $past(rst_n) && $past(clmp_r[7]) |->
    analog_ctl.clamp_active == ($past(clamp_in) == $past(clmp_r[6])))
    else $error("external clamp not honoured");
  AST_PWRDN: assert property (mode_r[3] [*4] |-> !activity_detect)
    else $error("activity high in power down");
  cover property ($rose(activity_detect));
  cover property ($changed(test_shift_out));
  cover property (port_b_oe);
  cover property (analog_ctl.coast_hold);
endmodule
`default_nettype wire

// >>> testbench/video_sink_model.sv
/*
  downstream controller model: reads port a, steers sample inversion.
  assumes the same clock and reset as the block.
*/
`timescale 1ns/1ps
`default_nettype none
module video_sink_model
  import video_sync_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   flip_en,
  input  wire logic   vert_sync_output,
  input  wire logic   port_a_oe,
  input  wire pixel_s port_a_o,
  output logic        sample_clock_invert,
  output pixel_s      bus_a
);
  logic   vs_d_r;
  pixel_s hold_r;
  // flip only at a frame start so the phase jump lands in blanking
  always_ff @(posedge clk)
  begin
    vs_d_r <= vert_sync_output;
    if (!rst_n)
      sample_clock_invert <= 1'b0;
    else if (flip_en && vert_sync_output && !vs_d_r)
      sample_clock_invert <= !sample_clock_invert;
  end
  // a released bus keeps no value: show a pattern that moves every cycle
  always_ff @(posedge clk)
    hold_r <= rst_n ? ~bus_a : 24'h5A5A5A;
  assign bus_a = port_a_oe ? port_a_o : hold_r;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
/*
  self-checking bench for the sync, clamp, clock and test-shift block.
  assumes the sink model and the checker compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_sync_map.svh"
module tb
  import video_sync_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, flip = 1'b0;
  logic hsync_in = 1'b1, vsync_in = 1'b0, csync_vsync = 1'b0;
  logic clamp_in = 1'b0, coast_in = 1'b0, pixel_valid = 1'b0;
  logic test_shift_clock = 1'b0, test_shift_in = 1'b0;
  logic test_shift_out, horiz_sync_output, vert_sync_output, h0, v0;
  logic pixel_out_clock, activity_detect, port_a_oe, port_b_oe;
  logic sample_clock_invert;
  logic digital_hsync = 1'b0, digital_vsync = 1'b0, digital_de = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] ra [7] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16};
  logic [7:0] rv [7] = '{`SYNC_CTRL_RST, `CLAMP_CTRL_RST, `CLAMP_DELAY_RST,
    `CLAMP_WIDTH_RST, 8'h00, `HSO_WIDTH_RST, 8'h00};
  pixel_s pixel_in = 24'h000000, port_a_o, port_b_o, bus_a;
  analog_ctl_s analog_ctl;
  logic [47:0] pat = 48'hA5C3_3C5A_F00F;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
  always #5 clk = ~clk;
  video_sync_clock_pin_control #(.ACT_WIDTH(4)) dut_u (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .hsync_in, .vsync_in, .csync_vsync, .digital_hsync,
    .digital_vsync, .digital_de, .clamp_in, .coast_in,
    .sample_clock_invert, .pixel_valid, .pixel_in, .test_shift_clock,
    .test_shift_in, .test_shift_out, .horiz_sync_output, .vert_sync_output,
    .pixel_out_clock, .activity_detect, .port_a_o, .port_b_o, .port_a_oe,
    .port_b_oe, .analog_ctl);
  video_sink_model sink_u (.clk, .rst_n, .flip_en(flip), .vert_sync_output,
    .port_a_oe, .port_a_o, .sample_clock_invert, .bus_a);
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic hs(input logic v);
    @(posedge clk);
    hsync_in <= v;
  endtask
  // clock held high then low two cycles each, above the one-cycle minimum
  task automatic sh(input logic b);
    @(posedge clk);
    test_shift_clock <= 1'b1;
    test_shift_in    <= b;
    repeat (2) @(posedge clk);
    test_shift_clock <= 1'b0;
    tick(2);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
    hs(1'b0);
    tick(3);
    check(activity_detect, 1);
    tick(25);
    check(activity_detect, 0);
    wr(8'h0F, 8'h90);
    rdc(8'h0F, 8'h90);
    hs(1'b1);
    tick(3);
    check(activity_detect, 1);
    tick(25);
    hs(1'b0);
    tick(3);
    check(activity_detect, 0);
    hs(1'b1);
    tick(3);
    wr(8'h16, 8'h08);
    tick(3);
    check(activity_detect, 0);
    check({port_a_oe, port_b_oe}, 0);
    wr(8'h16, 8'h00);
    tick(40);
    h0 = horiz_sync_output;
    v0 = vert_sync_output;
    wr(8'h0F, 8'hF0);
    tick(3);
    check(horiz_sync_output, !h0);
    check(vert_sync_output, !v0);
    @(posedge clk) csync_vsync <= 1'b1;
    wr(8'h0F, 8'hF8);
    tick(3);
    check(vert_sync_output, v0);
    wr(8'h14, 8'h05);
    hs(1'b0);
    tick(2);
    hs(1'b1);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 n += horiz_sync_output;
    end
    check(n, 5);
    wr(8'h0F, 8'hF0);
    @(posedge clk);
    flip     <= 1'b1;
    vsync_in <= 1'b1;
    tick(4);
    @(posedge clk) vsync_in <= 1'b0;
    tick(4);
    check(analog_ctl.invert_clk, 1);
    @(posedge clk);
    flip     <= 1'b0;
    clamp_in <= 1'b1;
    coast_in <= 1'b1;
    wr(8'h10, 8'hD0);
    tick(3);
    check(analog_ctl.clamp_active, 1);
    check(analog_ctl.use_ext_clk, 1);
    check(analog_ctl.coast_hold, 1);
    wr(8'h10, 8'hF0);
    tick(3);
    check(analog_ctl.clamp_mid, 1);
    wr(8'h10, 8'h00);
    // clamp pin still high but disabled: only the internal window counts
    hs(1'b0);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 n += analog_ctl.clamp_active;
    end
    check(n, `CLAMP_WIDTH_RST);
    hs(1'b1);
    wr(8'h16, 8'h04);
    for (int i = 47; i >= 0; i--) sh(pat[i]);
    hs(1'b0);
    hs(1'b1);
    tick(3);
    check({port_a_o, port_b_o}, pat);
    check(bus_a, pat[47:24]);
    check(test_shift_out, pat[47]);
    sh(1'b0);
    check(test_shift_out, pat[46]);
    check({port_a_o, port_b_o}, {pat[46:0], 1'b0});
    wr(8'h16, 8'h00);
    sh(1'b1);
    check(test_shift_out, pat[46]);
    wr(8'h16, 8'h02);
    hs(1'b0);
    hs(1'b1);
    h0 = pixel_out_clock;
    @(posedge clk);
    pixel_valid <= 1'b1;
    pixel_in    <= 24'h112233;
    @(posedge clk) pixel_in <= 24'h445566;
    @(posedge clk) pixel_valid <= 1'b0;
    tick(3);
    check(port_a_o, 24'h112233);
    check(port_b_o, 24'h445566);
    check(pixel_out_clock, !h0);
    check(port_b_oe, 1);
    rdc(8'h15, 8'h11);
    wr(8'h16, 8'h01);
    @(posedge clk);
    digital_de    <= 1'b1;
    digital_hsync <= 1'b1;
    digital_vsync <= 1'b1;
    tick(20);
    check(activity_detect, 1);
    check(horiz_sync_output, 1);
    check(vert_sync_output, 1);
    @(posedge clk) digital_de <= 1'b0;
    tick(20);
    check(activity_detect, 0);
    results();
  end
endmodule
bind video_sync_clock_pin_control video_sync_checker chk_u (.clk, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .clamp_in, .coast_in, .sample_clock_invert,
  .test_shift_clock, .test_shift_out, .activity_detect, .port_a_oe,
  .port_b_oe, .analog_ctl);
`default_nettype wire
